// [ssp_pkg.sv]
// constants shared by both ends of the serial register port
// assumes a 50 MHz core clock on each end and a host-made shift clock
package ssp_pkg;
  // frame geometry: counts of shift clock rising edges seen
  localparam logic [4:0] CNT_RW       = 5'h00;   // edge 1 carries direction
  localparam logic [4:0] CNT_IDX_LO   = 5'h01;   // edges 2..7 carry index
  localparam logic [4:0] CNT_IDX_HI   = 5'h06;
  localparam logic [4:0] CNT_DUMMY    = 5'h07;   // edge 8 is don't care
  localparam logic [4:0] CNT_DATA_LO  = 5'h08;   // edges 9..16 carry data
  localparam logic [4:0] CNT_LAST     = 5'h0F;   // count before 16th edge
  localparam logic [4:0] CNT_FRAME    = 5'h10;   // full frame, 16 bits
  localparam logic [4:0] CNT_ONE      = 5'h01;
  localparam logic [4:0] CNT_RD_LOAD  = 5'h08;   // falling edge 8 loads
  localparam logic [4:0] CNT_RD_FIRST = 5'h09;   // falling edge 9 drives d0
  localparam int         IDX_W        = 6;
  localparam int         DATA_W       = 8;
  localparam int         NUM_REGS     = 64;
  // direction bit encoding
  localparam logic       RW_WRITE     = 1'h0;
  localparam logic       RW_READ      = 1'h1;
  localparam logic       DUMMY_VAL    = 1'h0;
  localparam logic [7:0] REG_DEFAULT  = 8'h00;
  // long reset time
  localparam int         REF_CLK_HZ   = 50_000_000;
  localparam int         RST_HOLD_MS  = 10;
  localparam int         RST_HOLD_CYC_DEF = (REF_CLK_HZ / 1000) * RST_HOLD_MS;
  // host divider: last core cycle count of a shift clock half period
  localparam logic [2:0] HALF_LAST    = 3'h3;
  // host register word addresses and fields
  localparam logic [1:0] ADDR_CMD     = 2'h0;
  localparam logic [1:0] ADDR_STAT    = 2'h1;
  localparam logic [1:0] ADDR_RDATA   = 2'h2;
  localparam logic [1:0] ADDR_CTRL    = 2'h3;
  localparam int         CMD_DATA_LO  = 0;
  localparam int         CMD_IDX_LO   = 8;
  localparam int         CMD_RW_BIT   = 16;
  localparam int         STAT_BUSY    = 0;
  localparam int         STAT_DONE    = 1;
  localparam int         CTRL_RST     = 0;
endpackage

// [ssp_if.sv]
// link between the serial register port device and its host
// assumes the testbench instantiates it and ties both ends to it
`timescale 1ns/100ps
interface ssp_if;
  logic sel_n;            // frame select, active low
  logic sclk;             // shift clock, made by the host
  logic host_serial_in;   // host to device data
  logic host_serial_out;  // device to host data, valid when oe low
  logic serial_out_oe_n;  // device drives the data out line when low
  logic dev_rst_n;        // long reset pin, active low
  wire  sdo_line;         // resolved line, pulled high when undriven

  assign sdo_line = serial_out_oe_n ? 1'b1 : host_serial_out;

  modport dev (
    input  sel_n,
    input  sclk,
    input  host_serial_in,
    input  dev_rst_n,
    output host_serial_out,
    output serial_out_oe_n
  );
  modport host (
    output sel_n,
    output sclk,
    output host_serial_in,
    output dev_rst_n,
    input  sdo_line
  );
endinterface

// [ssp_dev.sv]
// device end of the serial register port: 64 registers of 8 bits
// assumes the host makes the shift clock and keeps it low between frames
//
// The Avalon-MM register port and the register addresses were decided locally.
`timescale 1ns/100ps
//
// Operation
// - every access is exactly sixteen bits
// - device samples serial input on rising edges
// - host sends every field lsb first
// - first bit zero writes, one reads
// - bits two to seven carry index
// - bit eight is ignored dummy
// - host sends write data on bits 9-16
// - write commits only when select rises
// - one access per select, no bursts
// - read data changes on falling edges
// - read bit zero after falling edge nine
// - read returns the indexed register contents
// - reset pin low 10ms restores defaults
module ssp_dev #(
  parameter int unsigned RST_HOLD_CYC = ssp_pkg::RST_HOLD_CYC_DEF  // long reset length in core cycles
) (
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  ssp_if.dev                            link,
  output logic                          upd_valid_ff,
  output logic [ssp_pkg::IDX_W-1:0]     upd_index_ff,
  output logic [ssp_pkg::DATA_W-1:0]    upd_data_ff,
  output logic                          defaults_ff
);
  localparam int RC_W = $clog2(RST_HOLD_CYC + 1);  // long reset counter width
  localparam logic [RC_W-1:0] RC_ONE  = RC_W'(1);
  localparam logic [RC_W-1:0] RC_HOLD = RC_W'(RST_HOLD_CYC);

  // ---------------- link clock domain ----------------
  logic [4:0]                    bit_cnt_ff;   // rising edges seen this frame
  logic                          rw_ff;        // direction of current frame
  logic [ssp_pkg::IDX_W-1:0]     idx_ff;       // index being shifted in
  logic [ssp_pkg::DATA_W-1:0]    data_sh_ff;   // write data being shifted in
  logic                          hold_rw_ff;   // completed frame, direction
  logic [ssp_pkg::IDX_W-1:0]     hold_idx_ff;  // completed frame, index
  logic [ssp_pkg::DATA_W-1:0]    hold_data_ff; // completed frame, data
  logic                          frame_tgl_ff; // flips once per full frame
  logic [ssp_pkg::DATA_W-1:0]    rd_sh_ff;     // read data being shifted out
  logic                          sdo_ff;       // data out value
  logic                          oe_n_ff;      // data out enable, low drives
  logic [ssp_pkg::DATA_W-1:0]    rd_word;      // register picked by index

  // ---------------- core clock domain ----------------
  logic [ssp_pkg::DATA_W-1:0]    reg_mem_ff [ssp_pkg::NUM_REGS];  // register file
  logic                          sel_s1_ff;    // select sync, first stage
  logic                          sel_s2_ff;    // select sync, second stage
  logic                          sel_s3_ff;    // previous synced select
  logic                          tgl_s1_ff;    // frame toggle sync, first stage
  logic                          tgl_s2_ff;    // frame toggle sync, second stage
  logic                          tgl_seen_ff;  // last frame toggle acted on
  logic                          rstp_s1_ff;   // reset pin sync, first stage
  logic                          rstp_s2_ff;   // reset pin sync, second stage
  logic [RC_W-1:0]               rst_cnt_ff;   // core cycles reset pin held low
  logic                          sel_rise;     // select just returned high
  logic                          frame_new;    // a full frame awaits commit
  logic                          long_rst;     // reset pin held long enough

  // bit counter; select high clears it, so a short frame leaves no trace
  always_ff @(posedge link.sclk or posedge link.sel_n) begin
    if (link.sel_n) begin
      bit_cnt_ff <= 5'h00;
    end else if (bit_cnt_ff != ssp_pkg::CNT_FRAME) begin
      bit_cnt_ff <= bit_cnt_ff + ssp_pkg::CNT_ONE;
    end
  end

  // field capture on rising edges, every field arrives lsb first
  always_ff @(posedge link.sclk or posedge rst) begin
    if (rst) begin
      rw_ff      <= ssp_pkg::RW_WRITE;
      idx_ff     <= '0;
      data_sh_ff <= '0;
    end else if (bit_cnt_ff == ssp_pkg::CNT_RW) begin
      rw_ff <= link.host_serial_in;
    end else if (bit_cnt_ff >= ssp_pkg::CNT_IDX_LO && bit_cnt_ff <= ssp_pkg::CNT_IDX_HI) begin
      idx_ff <= {link.host_serial_in, idx_ff[ssp_pkg::IDX_W-1:1]};
    end else if (bit_cnt_ff >= ssp_pkg::CNT_DATA_LO && bit_cnt_ff < ssp_pkg::CNT_FRAME) begin
      data_sh_ff <= {link.host_serial_in, data_sh_ff[ssp_pkg::DATA_W-1:1]};
    end
    // dummy edge and edges past the sixteenth fall through untouched
  end

  // hand-off of a complete frame: words held still, toggle announces them
  always_ff @(posedge link.sclk or posedge rst) begin
    if (rst) begin
      hold_rw_ff   <= ssp_pkg::RW_WRITE;
      hold_idx_ff  <= '0;
      hold_data_ff <= '0;
      frame_tgl_ff <= 1'b0;
    end else if (bit_cnt_ff == ssp_pkg::CNT_LAST) begin
      // only the sixteenth edge produces a frame
      hold_rw_ff   <= rw_ff;
      hold_idx_ff  <= idx_ff;
      hold_data_ff <= {link.host_serial_in, data_sh_ff[ssp_pkg::DATA_W-1:1]};
      frame_tgl_ff <= ~frame_tgl_ff;
    end
  end

  // register picked by the index; writes only land while select is high,
  // so only a long reset can change it across the falling edge that loads it
  assign rd_word = reg_mem_ff[idx_ff];

  // read data out on falling edges; select high parks the line
  always_ff @(negedge link.sclk or posedge link.sel_n) begin
    if (link.sel_n) begin
      rd_sh_ff <= '0;
      sdo_ff   <= 1'b1;
      oe_n_ff  <= 1'b1;
    end else if (rw_ff == ssp_pkg::RW_READ) begin
      if (bit_cnt_ff == ssp_pkg::CNT_RD_LOAD) begin
        rd_sh_ff <= rd_word;
      end else if (bit_cnt_ff >= ssp_pkg::CNT_RD_FIRST) begin
        sdo_ff   <= rd_sh_ff[0];
        rd_sh_ff <= {1'b0, rd_sh_ff[ssp_pkg::DATA_W-1:1]};
        oe_n_ff  <= 1'b0;
      end
    end
  end

  assign link.host_serial_out = sdo_ff;
  assign link.serial_out_oe_n = oe_n_ff;

  // synchronisers into the core clock
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sel_s1_ff  <= 1'b1;
      sel_s2_ff  <= 1'b1;
      sel_s3_ff  <= 1'b1;
      tgl_s1_ff  <= 1'b0;
      tgl_s2_ff  <= 1'b0;
      rstp_s1_ff <= 1'b1;
      rstp_s2_ff <= 1'b1;
    end else begin
      sel_s1_ff  <= link.sel_n;
      sel_s2_ff  <= sel_s1_ff;
      sel_s3_ff  <= sel_s2_ff;
      tgl_s1_ff  <= frame_tgl_ff;
      tgl_s2_ff  <= tgl_s1_ff;
      rstp_s1_ff <= link.dev_rst_n;
      rstp_s2_ff <= rstp_s1_ff;
    end
  end

  // commit on select rising, and only if a full frame came in
  assign sel_rise  = sel_s2_ff & ~sel_s3_ff;
  assign frame_new = tgl_s2_ff != tgl_seen_ff;
  assign long_rst  = rst_cnt_ff == (RC_HOLD - RC_ONE);

  // frame toggle bookkeeping
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tgl_seen_ff <= 1'b0;
    end else if (sel_rise && frame_new) begin
      tgl_seen_ff <= tgl_s2_ff;
    end
  end

  // long reset timer; saturates so defaults load once per low period
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rst_cnt_ff <= '0;
    end else if (rstp_s2_ff) begin
      rst_cnt_ff <= '0;
    end else if (rst_cnt_ff != RC_HOLD) begin
      rst_cnt_ff <= rst_cnt_ff + RC_ONE;
    end
  end

  // register file: long reset beats a write landing in the same cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < ssp_pkg::NUM_REGS; i++) begin
        reg_mem_ff[i] <= ssp_pkg::REG_DEFAULT;
      end
    end else if (long_rst) begin
      for (int i = 0; i < ssp_pkg::NUM_REGS; i++) begin
        reg_mem_ff[i] <= ssp_pkg::REG_DEFAULT;
      end
    end else if (sel_rise && frame_new && hold_rw_ff == ssp_pkg::RW_WRITE) begin
      reg_mem_ff[hold_idx_ff] <= hold_data_ff;
    end
  end

  // user side report of each committed write, one cycle pulse
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      upd_valid_ff <= 1'b0;
      upd_index_ff <= '0;
      upd_data_ff  <= '0;
    end else begin
      upd_valid_ff <= sel_rise && frame_new && hold_rw_ff == ssp_pkg::RW_WRITE && !long_rst;
      if (sel_rise && frame_new) begin
        upd_index_ff <= hold_idx_ff;
        upd_data_ff  <= hold_data_ff;
      end
    end
  end

  // pulse when the long reset restores defaults
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      defaults_ff <= 1'b0;
    end else begin
      defaults_ff <= long_rst;
    end
  end
endmodule

// [ssp_host.sv]
// host end of the serial register port, commanded over avalon-mm
// assumes a device end on the same interface; makes the shift clock
`timescale 1ns/100ps
module ssp_host (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  ssp_if.host              link,
  input  wire logic [1:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata_ff,
  output logic             avs_waitrequest_ff
);
  typedef enum logic [1:0] {HS_IDLE, HS_LOW, HS_HIGH, HS_GAP} ssp_hstate_e;

  ssp_hstate_e  state_ff;     // frame sequencer state
  logic [2:0]   half_ff;      // core cycles within a half period
  logic [4:0]   edge_ff;      // falling edges made this frame
  logic [15:0]  frame_ff;     // bits still to send, lsb next
  logic         rw_ff;        // direction of the running frame
  logic         sel_n_ff;     // select pin
  logic         sclk_ff;      // shift clock pin
  logic         sdi_ff;       // data pin
  logic         rst_n_ff;     // device reset pin
  logic [7:0]   rd_ff;        // read data gathered
  logic         done_ff;      // last frame finished
  logic         sdo_s1_ff;    // data in sync, first stage
  logic         sdo_s2_ff;    // data in sync, second stage
  logic         take;         // bus request accepted this cycle
  logic         start;        // command accepted while idle
  logic [15:0]  frame_new;    // frame built from the command word

  assign take  = avs_waitrequest_ff && (avs_read || avs_write);
  assign start = take && avs_write && avs_address == ssp_pkg::ADDR_CMD && state_ff == HS_IDLE;
  // data, dummy, index, direction from msb to lsb, so lsb leaves first
  assign frame_new = {avs_writedata[ssp_pkg::CMD_DATA_LO +: ssp_pkg::DATA_W],
                      ssp_pkg::DUMMY_VAL,
                      avs_writedata[ssp_pkg::CMD_IDX_LO +: ssp_pkg::IDX_W],
                      avs_writedata[ssp_pkg::CMD_RW_BIT]};

  assign link.sel_n          = sel_n_ff;
  assign link.sclk           = sclk_ff;
  assign link.host_serial_in = sdi_ff;
  assign link.dev_rst_n      = rst_n_ff;

  // bus slave: every request answered one cycle later, waitrequest low once
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest_ff <= 1'b1;
      avs_readdata_ff    <= 32'h0000_0000;
    end else if (take) begin
      avs_waitrequest_ff <= 1'b0;
      avs_readdata_ff    <= 32'h0000_0000;
      if (avs_read) begin
        case (avs_address)
          ssp_pkg::ADDR_STAT: begin
            avs_readdata_ff[ssp_pkg::STAT_BUSY] <= state_ff != HS_IDLE;
            avs_readdata_ff[ssp_pkg::STAT_DONE] <= done_ff;
          end
          ssp_pkg::ADDR_RDATA: avs_readdata_ff[ssp_pkg::DATA_W-1:0] <= rd_ff;
          ssp_pkg::ADDR_CTRL:  avs_readdata_ff[ssp_pkg::CTRL_RST] <= ~rst_n_ff;
          default:             avs_readdata_ff <= 32'h0000_0000;  // command reads as zero
        endcase
      end
    end else begin
      avs_waitrequest_ff <= 1'b1;
    end
  end

  // device reset pin under software; software times the low period
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rst_n_ff <= 1'b1;
    end else if (take && avs_write && avs_address == ssp_pkg::ADDR_CTRL) begin
      rst_n_ff <= ~avs_writedata[ssp_pkg::CTRL_RST];
    end
  end

  // data from the device is on the link clock's phase, so synchronise it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sdo_s1_ff <= 1'b1;
      sdo_s2_ff <= 1'b1;
    end else begin
      sdo_s1_ff <= link.sdo_line;
      sdo_s2_ff <= sdo_s1_ff;
    end
  end

  // frame sequencer and clock divider; half period is four core cycles,
  // long enough for the synchronised read bit to settle before sampling
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff <= HS_IDLE;
      half_ff  <= 3'h0;
      edge_ff  <= 5'h00;
      frame_ff <= 16'h0000;
      rw_ff    <= ssp_pkg::RW_WRITE;
      sel_n_ff <= 1'b1;
      sclk_ff  <= 1'b0;
      sdi_ff   <= 1'b0;
      rd_ff    <= 8'h00;
      done_ff  <= 1'b0;
    end else begin
      case (state_ff)
        HS_IDLE: begin
          if (start) begin
            frame_ff <= frame_new;
            rw_ff    <= frame_new[0];
            sdi_ff   <= frame_new[0];
            sel_n_ff <= 1'b0;
            edge_ff  <= 5'h00;
            half_ff  <= 3'h0;
            done_ff  <= 1'b0;
            state_ff <= HS_LOW;
          end
        end
        HS_LOW: begin
          if (half_ff != ssp_pkg::HALF_LAST) begin
            half_ff <= half_ff + 3'h1;
          end else begin
            half_ff <= 3'h0;
            if (rw_ff == ssp_pkg::RW_READ && edge_ff >= ssp_pkg::CNT_RD_FIRST) begin
              rd_ff <= {sdo_s2_ff, rd_ff[7:1]};
            end
            if (edge_ff == ssp_pkg::CNT_FRAME) begin
              sel_n_ff <= 1'b1;
              state_ff <= HS_GAP;
            end else begin
              sclk_ff  <= 1'b1;
              state_ff <= HS_HIGH;
            end
          end
        end
        HS_HIGH: begin
          if (half_ff != ssp_pkg::HALF_LAST) begin
            half_ff <= half_ff + 3'h1;
          end else begin
            half_ff  <= 3'h0;
            sclk_ff  <= 1'b0;
            edge_ff  <= edge_ff + ssp_pkg::CNT_ONE;
            frame_ff <= {1'b0, frame_ff[15:1]};
            sdi_ff   <= frame_ff[1];
            state_ff <= HS_LOW;
          end
        end
        HS_GAP: begin
          // select stays high a while so the device sees the frame end
          if (half_ff != ssp_pkg::HALF_LAST) begin
            half_ff <= half_ff + 3'h1;
          end else begin
            half_ff  <= 3'h0;
            done_ff  <= 1'b1;
            state_ff <= HS_IDLE;
          end
        end
        default: state_ff <= HS_IDLE;
      endcase
    end
  end
endmodule

// [ssp_sva.sv]
// timing checker for the link between host end and device end
// assumes the bench instantiates it beside the interface, core clock domain
`timescale 1ns/100ps
module ssp_sva (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic host_serial_in,
  input wire logic host_serial_out,
  input wire logic serial_out_oe_n,
  input wire logic dev_rst_n
);
  logic [4:0] rise_cnt_ff;  // shift clock rises in this frame
  logic [4:0] fall_cnt_ff;  // shift clock falls in this frame
  logic       dir_ff;       // direction bit of this frame

  // frame counters, cleared whenever select is high
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rise_cnt_ff <= 5'h00;
      fall_cnt_ff <= 5'h00;
    end else if (sel_n) begin
      rise_cnt_ff <= 5'h00;
      fall_cnt_ff <= 5'h00;
    end else begin
      rise_cnt_ff <= rise_cnt_ff + {4'h0, $rose(sclk)};
      fall_cnt_ff <= fall_cnt_ff + {4'h0, $fell(sclk)};
    end
  end

  // direction latched at the first rise only
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dir_ff <= 1'b0;
    end else if (!sel_n && $rose(sclk) && rise_cnt_ff == ssp_pkg::CNT_RW) begin
      dir_ff <= host_serial_in;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // host keeps each shift clock half for four core cycles
  sequence s_high_half;
    sclk [*4] ##1 !sclk;
  endsequence
  sequence s_low_half;
    !sclk [*4];
  endsequence

  a_oe_idle_sel: assert property (sel_n && $past(sel_n) |-> serial_out_oe_n)
    else $error("data out driven while deselected");
  a_oe_write_frm: assert property (!sel_n && rise_cnt_ff >= ssp_pkg::CNT_ONE && dir_ff == ssp_pkg::RW_WRITE
    |-> serial_out_oe_n)
    else $error("data out driven in a write frame");
  a_oe_early: assert property (!sel_n && fall_cnt_ff < ssp_pkg::CNT_RD_FIRST && !$fell(sclk) |-> serial_out_oe_n)
    else $error("data out driven before ninth fall");
  a_read_drive: assert property (!sel_n && dir_ff == ssp_pkg::RW_READ && fall_cnt_ff >= ssp_pkg::CNT_RD_FIRST
    |-> !serial_out_oe_n)
    else $error("read data not driven");
  a_out_on_fall: assert property (!serial_out_oe_n && $past(serial_out_oe_n) == 1'b0 && !$fell(sclk)
    |-> $stable(host_serial_out))
    else $error("data out changed off a falling edge");
  a_frame_len: assert property ($rose(sel_n) |-> rise_cnt_ff == ssp_pkg::CNT_FRAME)
    else $error("frame closed with wrong bit count");
  a_cnt_max: assert property (rise_cnt_ff <= ssp_pkg::CNT_FRAME)
    else $error("more than sixteen rises in one frame");
  a_sclk_idle: assert property (sel_n && dev_rst_n |-> !sclk)
    else $error("shift clock moves while deselected");
  a_sdi_hold: assert property (sclk |-> $stable(host_serial_in))
    else $error("serial input changed while clock high");
  a_high_half: assert property ($rose(sclk) |-> s_high_half)
    else $error("shift clock high half wrong");
  a_low_half: assert property ($fell(sclk) |-> s_low_half)
    else $error("shift clock low half wrong");
endmodule

// [serial_host_register_port_tb.sv]
// bench: host and device joined on one link, a second device driven here
// assumes the package, interface, both ends and the checker compile first
`timescale 1ns/100ps
module serial_host_register_port_tb;
  logic        ref_clk, rst;               // core clock and reset
  logic [1:0]  avs_address;                // bus word address
  logic        avs_read, avs_write;        // bus strobes
  logic [31:0] avs_writedata, rd_data, q;  // bus data, last answer
  logic        rd_wait;                    // bus stall
  logic        upd_valid, upd2_valid, dflt; // commit and default pulses
  logic [5:0]  upd_index, upd2_index, exp_idx;
  logic [7:0]  upd_data, upd2_data, exp_dat, rb;
  logic [7:0]  model [64];                 // expected register contents
  logic [31:0] rng;                        // xorshift state
  int          bad_count, samples_checked, upd_n, upd2_n, dflt_n, wr_n;
  ssp_if link ();
  ssp_if link2 ();

  ssp_host i_ssp_host (.ref_clk(ref_clk), .rst(rst), .link(link.host), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata_ff(rd_data),
    .avs_waitrequest_ff(rd_wait));
  ssp_dev #(.RST_HOLD_CYC(20)) i_ssp_dev (.ref_clk(ref_clk), .rst(rst), .link(link.dev),
    .upd_valid_ff(upd_valid), .upd_index_ff(upd_index), .upd_data_ff(upd_data), .defaults_ff(dflt));
  ssp_dev #(.RST_HOLD_CYC(20)) i_ssp_dev_2 (.ref_clk(ref_clk), .rst(rst), .link(link2.dev),
    .upd_valid_ff(upd2_valid), .upd_index_ff(upd2_index), .upd_data_ff(upd2_data), .defaults_ff());
  ssp_sva i_ssp_sva (.ref_clk(ref_clk), .rst(rst), .sel_n(link.sel_n), .sclk(link.sclk),
    .host_serial_in(link.host_serial_in), .host_serial_out(link.host_serial_out),
    .serial_out_oe_n(link.serial_out_oe_n), .dev_rst_n(link.dev_rst_n));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // one bus cycle; request held until stall is seen low at an edge
  task automatic bus(input logic wr, input logic [1:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    // no local limit: only the watchdog ends a hung wait
    do begin
      @(posedge ref_clk);
    end while (rd_wait !== 1'b0);
    q = rd_data;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  // one host frame; dup sends a second command while busy, which is dropped
  task automatic op(input logic rw, input logic [5:0] idx, input logic [7:0] d, input logic dup);
    int n;
    n = 0;
    exp_idx = idx;
    exp_dat = d;
    bus(1'b1, ssp_pkg::ADDR_CMD, {15'h0, rw, 2'h0, idx, d});
    if (dup) bus(1'b1, ssp_pkg::ADDR_CMD, {15'h0, ssp_pkg::RW_WRITE, 2'h0, ~idx, ~d});
    do begin
      bus(1'b0, ssp_pkg::ADDR_STAT, 32'h0);
      n++;
    end while (q[ssp_pkg::STAT_DONE] !== 1'b1 && n < 200);
    // done set and busy clear; a poll that ran out fails here too
    check("status at frame end", q, 32'h1 << ssp_pkg::STAT_DONE);
    if (rw == ssp_pkg::RW_READ) begin
      bus(1'b0, ssp_pkg::ADDR_RDATA, 32'h0);
      check("read byte", q, {24'h0, model[idx]});
    end else begin
      model[idx] = d;
      wr_n++;
    end
  endtask

  // frame on the second link, 80 ns shift clock off the core phase
  task automatic frame2(input logic [15:0] b, input int nb);
    @(posedge ref_clk);
    #7 link2.sel_n = 1'b0;
    for (int k = 0; k < nb; k++) begin
      link2.host_serial_in = b[k];
      #20 link2.sclk = 1'b1;
      #40 link2.sclk = 1'b0;
      #20 if (k >= 8) rb[3'(k - 8)] = link2.sdo_line;
    end
    link2.host_serial_in = ~link2.host_serial_in;
    #20 link2.sel_n = 1'b1;
    #200;
  endtask

  // commits carry the frame's fields, only once select is back high
  always @(posedge ref_clk) begin
    if (upd_valid === 1'b1) begin
      upd_n++;
      check("commit fields", {18'h0, upd_index, upd_data}, {18'h0, exp_idx, exp_dat});
      check("select at commit", {31'h0, link.sel_n}, 32'h1);
    end
    if (upd2_valid === 1'b1) upd2_n++;
    if (dflt === 1'b1) dflt_n++;
  end

  initial begin
    #1_500_000;
    bad_count++;
    test_done();
  end

  initial begin
    // non-blocking so every reset edge is seen by processes already waiting
    rst <= 1'b1;
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    {bad_count, samples_checked, upd_n, upd2_n, dflt_n, wr_n} = '0;
    rng = 32'h0000810D;
    foreach (model[i]) model[i] = ssp_pkg::REG_DEFAULT;
    repeat (20) @(posedge ref_clk);
    // second link parked after start-up, so its select edge clears the device
    {link2.sel_n, link2.sclk, link2.host_serial_in, link2.dev_rst_n} = 4'h9;
    rst <= 1'b0;
    bus(1'b0, ssp_pkg::ADDR_CMD, 32'h0);
    check("command reads zero", q, 32'h0);
    op(ssp_pkg::RW_READ, 6'h3F, 8'h00, 1'b0);
    // end indices, lone bits, all ones; then random traffic
    for (int i = 0; i < 4; i++) begin
      op(ssp_pkg::RW_WRITE, 6'(i * 21), 8'h01 << (i * 3) | {8{i == 3}}, i == 1);
      op(ssp_pkg::RW_READ, 6'(i * 21), 8'h00, 1'b0);
    end
    repeat (40) begin
      rng = xs(rng);
      op(rng[16], rng[13:8], rng[7:0], rng[20] & rng[21]);
    end
    check("commit count", 32'(upd_n), 32'(wr_n));
    // short reset pulse keeps contents, long one restores defaults
    bus(1'b1, ssp_pkg::ADDR_CTRL, 32'h1);
    bus(1'b1, ssp_pkg::ADDR_CTRL, 32'h0);
    repeat (30) @(posedge ref_clk);
    check("short reset pulse", 32'(dflt_n), 32'h0);
    bus(1'b1, ssp_pkg::ADDR_CTRL, 32'h1);
    bus(1'b0, ssp_pkg::ADDR_CTRL, 32'h0);
    check("reset pin control", q, 32'h1);
    repeat (40) @(posedge ref_clk);
    bus(1'b1, ssp_pkg::ADDR_CTRL, 32'h0);
    check("long reset pulse", 32'(dflt_n), 32'h1);
    foreach (model[i]) model[i] = ssp_pkg::REG_DEFAULT;
    op(ssp_pkg::RW_READ, 6'h3F, 8'h00, 1'b0);
    op(ssp_pkg::RW_READ, rng[13:8], 8'h00, 1'b0);
    // second link: dummy bit set, short frame, read back
    rng = xs(rng);
    frame2({rng[7:0], 1'b1, rng[13:8], ssp_pkg::RW_WRITE}, 16);
    check("line idle in write", {24'h0, rb}, 32'hFF);
    check("one commit", 32'(upd2_n), 32'h1);
    check("commit2 fields", {18'h0, upd2_index, upd2_data}, {18'h0, rng[13:0]});
    frame2({~rng[7:0], 1'b0, rng[13:8], ssp_pkg::RW_WRITE}, 15);
    check("short frame dropped", 32'(upd2_n), 32'h1);
    frame2({8'h00, 1'b0, rng[13:8], ssp_pkg::RW_READ}, 16);
    check("read back order", {24'h0, rb}, {24'h0, rng[7:0]});
    test_done();
  end
endmodule
